// ==== demr_defines.svh ====
`ifndef DEMR_DEFINES_SVH
`define DEMR_DEFINES_SVH

// bank-address select codes {ba2,ba1,ba0}
`define DEMR_SEL_EXT_ONE    3'h1
`define DEMR_SEL_EXT_TWO    3'h2
`define DEMR_SEL_EXT_THREE  3'h3
// field positions in the address word
`define DEMR_HT_RATE_BIT    7
`define DEMR_CAL_LSB        7
`define DEMR_CAL_MSB        9
`define DEMR_RSV_TOP_BIT    13
// calibration exit code
`define DEMR_CAL_EXIT       3'h0
// masks of bits kept per register; everything else is reserved zero
`define DEMR_ONE_KEEP_MASK  14'h1FFF
`define DEMR_TWO_KEEP_MASK  14'h0087
`define DEMR_THREE_KEEP_MASK 14'h0000
// mode register set cycle time, in clocks, and width of its wait counter
`define DEMR_TMRD_CK        2
`define DEMR_TMRD_W         4

`endif

// ==== demr_pkg.sv ====
package demr_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    DEMR_IDLE,
    DEMR_PRECHARGE,
    DEMR_PRE_WAIT,
    DEMR_LOAD,
    DEMR_MRD_WAIT
  } demr_state_e;
  // requested register
  typedef logic [1:0] demr_sel_t;
endpackage

// ==== demr_wait_cnt.sv ====
`include "demr_defines.svh"

// down counter: loads a count and reports when it reaches zero
module demr_wait_cnt #(
  parameter int W = `DEMR_TMRD_W
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_ff;   // remaining clocks
  logic [W-1:0] nxt_cnt;

  // next count: load, else step down to zero
  always_comb begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = count;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - W'(1);
    end
  end

  // register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign done = (cnt_ff == '0) && !load;
endmodule

// ==== demr_ctrl.sv ====
`include "demr_defines.svh"

module demr_ctrl #(
  parameter int TMRD_CK = `DEMR_TMRD_CK
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        req,
  input  wire logic [1:0]  req_sel,
  input  wire logic [13:0] req_data,
  input  wire logic        init_done,
  output logic             busy,
  output logic             done,
  output logic             cal_exit_seen,
  output logic             mem_cke,
  output logic             mem_cs_n,
  output logic             mem_ras_n,
  output logic             mem_cas_n,
  output logic             mem_we_n,
  output logic [2:0]       mem_ba,
  output logic [13:0]      mem_addr
);
  demr_pkg::demr_state_e st_ff;      // sequencer state
  demr_pkg::demr_state_e nxt_st;
  demr_pkg::demr_sel_t   sel_ff;     // latched register choice
  demr_pkg::demr_sel_t   nxt_sel;
  logic [13:0]           word_ff;    // latched, masked word
  logic [13:0]           nxt_word;
  logic                  busy_ff;
  logic                  nxt_busy;
  logic                  done_ff;
  logic                  nxt_done;
  logic                  cal_ff;
  logic                  nxt_cal;
  logic                  cke_ff;
  logic                  nxt_cke;
  logic [3:0]            cmd_ff;     // {cs_n,ras_n,cas_n,we_n}
  logic [3:0]            nxt_cmd;
  logic [2:0]            ba_ff;
  logic [2:0]            nxt_ba;
  logic [13:0]           addr_ff;
  logic [13:0]           nxt_addr;
  logic                  cnt_load;   // start wait counter
  logic                  cnt_done;
  logic [13:0]           keep_mask;  // bits allowed per register
  logic [2:0]            sel_code;   // bank code per register
  logic                  two_seen_ff;    // extended two written since reset
  logic                  nxt_two_seen;
  logic                  three_seen_ff;  // extended three written since reset
  logic                  nxt_three_seen;

  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] WAIT_CK = 4'(TMRD_CK - 1);

  // wait counter shared by precharge and mode set waits
  demr_wait_cnt #(.W(`DEMR_TMRD_W)) u_wait (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (cnt_load),
    .count    (WAIT_CK),
    .done     (cnt_done)
  );

  // reserved bits forced to zero per register
  always_comb begin
    case (req_sel)
      2'h1:    keep_mask = `DEMR_ONE_KEEP_MASK;
      2'h2:    keep_mask = `DEMR_TWO_KEEP_MASK;
      2'h3:    keep_mask = `DEMR_THREE_KEEP_MASK;
      default: keep_mask = 14'h0000;
    endcase
  end

  // bank select code of latched register
  always_comb begin
    case (sel_ff)
      2'h1:    sel_code = `DEMR_SEL_EXT_ONE;
      2'h2:    sel_code = `DEMR_SEL_EXT_TWO;
      2'h3:    sel_code = `DEMR_SEL_EXT_THREE;
      default: sel_code = 3'h0;
    endcase
  end

  // sequencer next state and pin values
  always_comb begin
    nxt_st   = st_ff;
    nxt_sel  = sel_ff;
    nxt_word = word_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_cal  = cal_ff;
    nxt_two_seen   = two_seen_ff;
    nxt_three_seen = three_seen_ff;
    nxt_cke  = 1'b1;                 // cke high, no self refresh
    nxt_cmd  = CMD_NOP;
    nxt_ba   = 3'h0;
    nxt_addr = 14'h0000;
    cnt_load = 1'b0;
    case (st_ff)
      demr_pkg::DEMR_IDLE: begin
        nxt_busy = 1'b0;
        if (req) begin
          nxt_sel  = req_sel;
          nxt_word = req_data & keep_mask;
          nxt_busy = 1'b1;
          nxt_st   = demr_pkg::DEMR_PRECHARGE;
        end
      end
      demr_pkg::DEMR_PRECHARGE: begin
        nxt_cmd      = CMD_PRE;       // precharge all banks
        nxt_addr[10] = 1'b1;
        cnt_load     = 1'b1;
        nxt_st       = demr_pkg::DEMR_PRE_WAIT;
      end
      demr_pkg::DEMR_PRE_WAIT: begin
        if (cnt_done) begin
          nxt_st = demr_pkg::DEMR_LOAD;
        end
      end
      demr_pkg::DEMR_LOAD: begin
        nxt_cmd  = CMD_MRS;
        nxt_ba   = sel_code;
        nxt_addr = word_ff;
        if (sel_ff == 2'h1) begin
          nxt_cal = (word_ff[`DEMR_CAL_MSB:`DEMR_CAL_LSB]
                     == `DEMR_CAL_EXIT);
        end
        // remember which init-time registers have been written
        if (sel_ff == 2'h2) begin
          nxt_two_seen = 1'b1;
        end
        if (sel_ff == 2'h3) begin
          nxt_three_seen = 1'b1;
        end
        cnt_load = 1'b1;
        nxt_st   = demr_pkg::DEMR_MRD_WAIT;
      end
      demr_pkg::DEMR_MRD_WAIT: begin
        if (cnt_done) begin
          nxt_done = 1'b1;
          nxt_busy = 1'b0;
          nxt_st   = demr_pkg::DEMR_IDLE;
        end
      end
      default: nxt_st = demr_pkg::DEMR_IDLE;
    endcase
  end

  // register sequencer state and pins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff   <= demr_pkg::DEMR_IDLE;
      sel_ff  <= 2'h0;
      word_ff <= 14'h0000;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      cal_ff  <= 1'b0;
      two_seen_ff   <= 1'b0;
      three_seen_ff <= 1'b0;
      cke_ff  <= 1'b0;
      cmd_ff  <= 4'hF;
      ba_ff   <= 3'h0;
      addr_ff <= 14'h0000;
    end else begin
      st_ff   <= nxt_st;
      sel_ff  <= nxt_sel;
      word_ff <= nxt_word;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      cal_ff  <= nxt_cal;
      two_seen_ff   <= nxt_two_seen;
      three_seen_ff <= nxt_three_seen;
      cke_ff  <= nxt_cke;
      cmd_ff  <= nxt_cmd;
      ba_ff   <= nxt_ba;
      addr_ff <= nxt_addr;
    end
  end

  assign busy          = busy_ff;
  assign done          = done_ff;
  assign cal_exit_seen = cal_ff;
  assign mem_cke       = cke_ff;
  assign mem_cs_n      = cmd_ff[3];
  assign mem_ras_n     = cmd_ff[2];
  assign mem_cas_n     = cmd_ff[1];
  assign mem_we_n      = cmd_ff[0];
  assign mem_ba        = ba_ff;
  assign mem_addr      = addr_ff;

  // init_done: user claims initialization ended; two and three must be set

  // checks
  sequence s_mrs;
    cmd_ff == CMD_MRS;
  endsequence
  sequence s_pre;
    cmd_ff == CMD_PRE && addr_ff[10];
  endsequence

  AST_ONE_TOP_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_mrs and ba_ff == 3'h1 |-> !addr_ff[13])
    else $error("reserved top bit set");
  AST_TWO_RSV: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_mrs and ba_ff == 3'h2 |-> (addr_ff & 14'h3F78) == 14'h0000)
    else $error("reserved bits set in register two");
  AST_THREE_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_mrs and ba_ff == 3'h3 |-> addr_ff == 14'h0000)
    else $error("register three address nonzero");
  AST_PRE_FIRST: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_pre |-> ##[1:3] s_mrs)
    else $error("mode set not after precharge");
  AST_CKE_HIGH: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_mrs |-> mem_cke && $past(mem_cke))
    else $error("cke low around mode set");
  AST_MRD_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_mrs |=> !done_ff ##[0:3] done_ff)
    else $error("done timing wrong");
  AST_NO_CMD_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_mrs |=> cmd_ff == CMD_NOP)
    else $error("command during mode set wait");
  AST_INIT_WRITES: assert property (@(posedge core_clk) disable iff (!rst_n)
    init_done |-> two_seen_ff && three_seen_ff)
    else $error("init done before registers two and three");
  AST_BA2_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_mrs |-> !ba_ff[2])
    else $error("ba2 high on mode set");
endmodule

// ==== demr_dev_model.sv ====
// behavioural device: decodes the command pins and holds extended registers
module demr_dev_model (
  input  wire logic        core_clk,
  input  wire logic        mem_cke,
  input  wire logic        mem_cs_n,
  input  wire logic        mem_ras_n,
  input  wire logic        mem_cas_n,
  input  wire logic        mem_we_n,
  input  wire logic [2:0]  mem_ba,
  input  wire logic [13:0] mem_addr,
  output logic      [13:0] ext_one,
  output logic      [13:0] ext_two,
  output logic      [13:0] ext_three,
  output logic             order_err,
  output logic      [7:0]  mrs_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pre_ok;    // all banks precharged
  logic cke_prev;  // clock enable at the previous edge
  initial begin
    order_err = 1'b0;
    pre_ok    = 1'b0;
    cke_prev  = 1'b0;
    mrs_cnt   = 8'h00;
  end
  // commands taken from pin levels at the rising edge only
  always @(posedge core_clk) begin
    cke_prev <= mem_cke;
    if (cke_prev && !mem_cke) order_err <= 1'b1;
    if (cke_prev && mem_cke && !mem_cs_n && !mem_ras_n && !mem_we_n) begin
      if (mem_cas_n && mem_addr[10]) begin
        pre_ok <= 1'b1; // precharge all
      end else if (!mem_cas_n) begin
        if (!pre_ok) order_err <= 1'b1;
        mrs_cnt <= mrs_cnt + 8'h01;
        // bank bits pick the register that latches the word
        case (mem_ba)
          3'h1: ext_one <= mem_addr;
          3'h2: ext_two <= mem_addr;
          3'h3: ext_three <= mem_addr;
          default: ;
        endcase
      end
    end
  end
endmodule

// ==== demr_ctrl_tb.sv ====
module demr_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst_n, req, init_done, busy, done, cal_exit_seen;
  logic        mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, order_err;
  logic [1:0]  req_sel;
  logic [2:0]  mem_ba;
  logic [7:0]  mrs_cnt;
  logic [13:0] req_data, mem_addr, ext_one, ext_two, ext_three;
  int          num_errors, checks_done, cycles;
  always #4 core_clk = ~core_clk;
  demr_ctrl #(.TMRD_CK(2)) demr_ctrl_inst (.core_clk(core_clk),
    .rst_n(rst_n), .req(req), .req_sel(req_sel), .req_data(req_data),
    .init_done(init_done), .busy(busy), .done(done),
    .cal_exit_seen(cal_exit_seen), .mem_cke(mem_cke), .mem_cs_n(mem_cs_n),
    .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
    .mem_ba(mem_ba), .mem_addr(mem_addr));
  demr_dev_model demr_dev_model_inst (.core_clk(core_clk),
    .mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
    .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba),
    .mem_addr(mem_addr), .ext_one(ext_one), .ext_two(ext_two),
    .ext_three(ext_three), .order_err(order_err), .mrs_cnt(mrs_cnt));
  // counts a comparison and reports a mismatch
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  // one request, bounded wait for the done pulse
  task automatic write_reg(input logic [1:0] sel, input logic [13:0] data);
    int lat;
    @(negedge core_clk);
    req = 1'b1;
    req_sel = sel;
    req_data = data;
    @(negedge core_clk);
    req = 1'b0;
    lat = 1;
    while (done !== 1'b1 && lat < 20) begin
      @(negedge core_clk);
      lat++;
    end
    // precharge, its wait, mode set and its wait: done at seventh fall
    check(lat == 7 && busy === 1'b0, "done latency");
  endtask
  // top bit dropped, calibration exit seen
  task automatic t_one();
    write_reg(2'h1, 14'h3C00);
    check(ext_one === 14'h1C00, "ext one word");
    check(cal_exit_seen === 1'b1, "cal exit");
    write_reg(2'h1, 14'h0380);
    check(cal_exit_seen === 1'b0 && ext_one === 14'h0380, "cal");
  endtask
  // reserved bits cleared, rate and range fields, back-to-back rewrite
  task automatic t_two();
    write_reg(2'h2, 14'h3FFF);
    check(ext_two === 14'h0087, "ext two word");
    check(ext_one === 14'h0380, "ext one kept");
    write_reg(2'h2, 14'h0006);
    check(ext_two === 14'h0006, "quarter range");
  endtask
  // third register always all zero
  task automatic t_three();
    write_reg(2'h3, 14'h3FFF);
    check(ext_three === 14'h0000, "ext three word");
  endtask
  // a request during busy is ignored
  task automatic t_busy();
    logic [7:0] n0;
    n0 = mrs_cnt;
    @(negedge core_clk);
    req = 1'b1;
    req_sel = 2'h3;
    req_data = 14'h0000;
    @(negedge core_clk);
    @(negedge core_clk);
    req = 1'b0;
    repeat (20) @(negedge core_clk);
    check(mrs_cnt === n0 + 8'h01, "one mode set only");
    check(order_err === 1'b0 && mem_cke === 1'b1, "order");
  endtask
  task automatic final_report();
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // stops a hung run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    req = 1'b0;
    req_sel = 2'h0;
    req_data = 14'h0000;
    init_done = 1'b0;
    num_errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    t_one();
    t_two();
    t_three();
    init_done = 1'b1;
    t_busy();
    final_report();
  end
endmodule
